// >>> src/smrts_shadow.sv
// APB shadow register holding DRAM mode register two settings.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "smrts_consts.svh"
module smrts_shadow #(
  parameter int ADDR_W = 12
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire logic                mrs_ack,
  output logic                     mrs_req,
  output logic [15:0]              mrs_value,
  output smrts_pkg::smrts_dts_t    dyn_term,
  output smrts_pkg::smrts_srt_t    temp_range,
  output logic                     auto_self_refresh,
  output logic [3:0]               write_latency,
  output logic [7:0]               refresh_banks
);
  import smrts_pkg::*;

  initial begin
    if (ADDR_W < 4 || ADDR_W > 12) begin
      $error("smrts_shadow: ADDR_W must lie between 4 and 12");
    end
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [11:0]       ofs);
    hit = (12'(a) == ofs);
  endfunction : hit

  logic        access;
  logic        wr_en;
  logic        sel_shadow;
  logic        sel_decode;
  logic        sel_ctrl;
  logic        mapped;
  logic [15:0] shadow_reg;
  logic [15:0] shadow_next;
  logic [7:0]  bank_mask;
  logic        apb_done_reg;

  // Single wait state: the second access cycle answers, then pready drops.
  // Writes commit only at the edge where the master sees pready high, so
  // a master that aborts before the answer leaves no trace behind.
  assign access     = psel && penable && !apb_done_reg;
  assign sel_shadow = hit(paddr, `SMRTS_OFS_SHADOW);
  assign sel_decode = hit(paddr, `SMRTS_OFS_DECODE);
  assign sel_ctrl   = hit(paddr, `SMRTS_OFS_MRS_CTRL);
  assign mapped     = sel_shadow || sel_decode || sel_ctrl;
  assign wr_en      = pready && psel && penable && pwrite && mapped;

  // ---------------------------------------------------------------
  // Shadow storage
  // ---------------------------------------------------------------
  // Only the low half is stored; the upper half has no flops at all,
  // so a write there cannot leak back on a read.
  always_comb begin
    shadow_next = shadow_reg;
    if (pstrb[0]) begin
      shadow_next[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      shadow_next[15:8] = pwdata[15:8];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shadow_reg <= `SMRTS_RESET_SHADOW;
    end else if (wr_en && sel_shadow) begin
      // Reserved bits are stored as written so the MRS word matches
      // software exactly; keeping them zero is software's job.
      shadow_reg <= shadow_next;
    end
  end

  // ---------------------------------------------------------------
  // Mode register set request
  // ---------------------------------------------------------------
  // Software writes bit 0 of the control word to ask the controller to
  // issue the MRS; the request stays high until the controller acks.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mrs_req <= 1'b0;
    end else if (wr_en && sel_ctrl && pstrb[0] && pwdata[0]) begin
      mrs_req <= 1'b1;
    end else if (mrs_ack) begin
      mrs_req <= 1'b0;
    end
  end

  // The value is latched when the request rises and held while it is
  // pending, so a rewrite mid-command cannot tear the MRS word.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mrs_value <= `SMRTS_RESET_SHADOW;
    end else if (!mrs_req) begin
      mrs_value <= shadow_reg;
    end
  end

  // ---------------------------------------------------------------
  // Decoded field outputs
  // ---------------------------------------------------------------
  smrts_bank_decode u_bank_decode (
    .par_code  (shadow_reg[`SMRTS_PAR_MSB:`SMRTS_PAR_LSB]),
    .bank_mask (bank_mask)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dyn_term          <= SMRTS_DTS_OFF;
      temp_range        <= SMRTS_SRT_NORMAL;
      auto_self_refresh <= 1'b0;
      write_latency     <= `SMRTS_WL_BASE;
      refresh_banks     <= 8'hFF;
    end else begin
      dyn_term <= smrts_dts_t'(
        shadow_reg[`SMRTS_DTS_MSB:`SMRTS_DTS_LSB]);
      temp_range <= smrts_srt_t'(
        shadow_reg[`SMRTS_SRT_BIT]);
      // With auto self-refresh off the device trusts the temperature
      // bit as programmed; nothing here second-guesses it.
      auto_self_refresh <= shadow_reg[`SMRTS_ASR_BIT];
      // Code 000..111 maps to 5..12 clocks.
      write_latency <= `SMRTS_WL_BASE +
        {1'b0, shadow_reg[`SMRTS_WLS_MSB:`SMRTS_WLS_LSB]};
      refresh_banks <= bank_mask;
    end
  end

  // ---------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (sel_shadow) begin
      rd_word = {16'h0000, shadow_reg};
    end else if (sel_decode) begin
      rd_word = {12'h000, refresh_banks, 1'b0, write_latency,
                 auto_self_refresh, temp_range, dyn_term, 3'h0};
    end else if (sel_ctrl) begin
      rd_word = {31'h0000_0000, mrs_req};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      apb_done_reg <= 1'b0;
      pready       <= 1'b0;
      prdata       <= 32'h0000_0000;
      pslverr      <= 1'b0;
    end else begin
      apb_done_reg <= psel && penable && !apb_done_reg;
      pready       <= access;
      pslverr      <= access && !mapped;
      prdata       <= (access && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

endmodule : smrts_shadow

// >>> src/smrts_consts.svh
// Register offsets, field positions, reset values and encodings.
`ifndef SMRTS_CONSTS_SVH
`define SMRTS_CONSTS_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define SMRTS_OFS_SHADOW      12'h000
`define SMRTS_OFS_DECODE      12'h004
`define SMRTS_OFS_MRS_CTRL    12'h008
`define SMRTS_RESET_SHADOW    16'h0000

// ---------------------------------------------------------------
// Field positions of the shadow word
// ---------------------------------------------------------------
`define SMRTS_RSVD_HI_MSB     15
`define SMRTS_RSVD_HI_LSB     11
`define SMRTS_DTS_MSB         10
`define SMRTS_DTS_LSB         9
`define SMRTS_RSVD_B8         8
`define SMRTS_SRT_BIT         7
`define SMRTS_ASR_BIT         6
`define SMRTS_WLS_MSB         5
`define SMRTS_WLS_LSB         3
`define SMRTS_PAR_MSB         2
`define SMRTS_PAR_LSB         0

// ---------------------------------------------------------------
// Encodings
// ---------------------------------------------------------------
`define SMRTS_DTS_RESERVED    2'h3
`define SMRTS_WL_BASE         4'h5

`endif

// >>> src/smrts_pkg.sv
// Types shared by the mode register two shadow design.
package smrts_pkg;

  typedef enum logic [1:0] {
    SMRTS_DTS_OFF,
    SMRTS_DTS_RZQ4,
    SMRTS_DTS_RZQ2,
    SMRTS_DTS_RSVD
  } smrts_dts_t;

  typedef enum logic {
    SMRTS_SRT_NORMAL,
    SMRTS_SRT_EXTENDED
  } smrts_srt_t;

endpackage : smrts_pkg

// >>> src/smrts_bank_decode.sv
// Decoder from partial array refresh code to an eight-bank refresh mask.
`timescale 1ns/1ns
module smrts_bank_decode (
  input  wire logic [2:0] par_code,
  output logic      [7:0] bank_mask
);

  always_comb begin
    case (par_code)
      3'h0:    bank_mask = 8'hFF;
      3'h1:    bank_mask = 8'h0F;
      3'h2:    bank_mask = 8'h03;
      3'h3:    bank_mask = 8'h01;
      3'h4:    bank_mask = 8'hFC;
      3'h5:    bank_mask = 8'hF0;
      3'h6:    bank_mask = 8'hC0;
      default: bank_mask = 8'h80;
    endcase
  end

endmodule : smrts_bank_decode

// >>> test/smrts_shadow_props.sv
// Concurrent checks on the ports of the mode register two shadow.
`timescale 1ns/1ns
module smrts_shadow_props #(
  parameter int ADDR_W = 12
) (
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_W-1:0]     paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic                  pready,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  input wire logic                  mrs_ack,
  input wire logic                  mrs_req,
  input wire logic [15:0]           mrs_value,
  input wire smrts_pkg::smrts_dts_t dyn_term,
  input wire smrts_pkg::smrts_srt_t temp_range,
  input wire logic                  auto_self_refresh,
  input wire logic [3:0]            write_latency,
  input wire logic [7:0]            refresh_banks
);
  import smrts_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire wr0 = pready && pwrite && paddr == '0;
  wire go = pready && psel && penable && pwrite;
  rsvd_read_zero_a: assert property (pready && !pwrite && paddr == '0
    |-> prdata[31:16] == 16'h0) else $error("upper half not zero");
  dts_follow_a: assert property (wr0 && pstrb[1]
    |=> ##1 dyn_term == $past(pwdata[10:9], 2)) else $error("dts wrong");
  temp_follow_a: assert property (wr0 && pstrb[0]
    |=> ##1 temp_range == $past(pwdata[7], 2)) else $error("srt wrong");
  asr_follow_a: assert property (wr0 && pstrb[0]
    |=> ##1 auto_self_refresh == $past(pwdata[6], 2))
    else $error("asr wrong");
  wl_follow_a: assert property (wr0 && pstrb[0]
    |=> ##1 write_latency == 4'h5 + $past(pwdata[5:3], 2))
    else $error("wl wrong");
  full_array_a: assert property (wr0 && pstrb[0] && pwdata[2:0] == 3'h0
    |=> ##1 refresh_banks == 8'hFF) else $error("banks wrong");
  mrs_frozen_a: assert property (mrs_req && $past(mrs_req)
    |-> $stable(mrs_value)) else $error("mrs value moved");
  mrs_clear_a: assert property (mrs_ack && !(go && paddr == 'h8)
    |=> !mrs_req) else $error("mrs req stuck");
  one_wait_a: assert property ($rose(penable) && psel
    |=> pready ##1 !pready) else $error("pready timing");
  c_write: cover property (wr0);
  c_ack: cover property (mrs_ack);
  c_err: cover property (pready && pslverr);
endmodule : smrts_shadow_props
bind smrts_shadow smrts_shadow_props #(.ADDR_W(ADDR_W)) smrts_shadow_props_inst (.*);

// >>> test/smrts_mrs_partner.sv
// Controller side model that issues the mode register set and acks it.
`timescale 1ns/1ns
module smrts_mrs_partner (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        mrs_req,
  input  wire logic [15:0] mrs_value,
  input  wire logic [3:0]  dly,
  output logic             mrs_ack,
  output logic [15:0]      applied
);
  logic [3:0] cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0; mrs_ack <= 1'b0; applied <= 16'h0;
    end else begin
      mrs_ack <= 1'b0;
      if (mrs_req && !mrs_ack && cnt >= dly) begin
        mrs_ack <= 1'b1; applied <= mrs_value; cnt <= 4'h0;
      end else if (mrs_req && !mrs_ack) cnt <= cnt + 4'h1;
    end
  end
endmodule : smrts_mrs_partner

// >>> test/smrts_shadow_bench.sv
// Register level bench for the mode register two shadow.
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module smrts_shadow_bench;
  import smrts_pkg::*;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, mrs_ack;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, w;
  logic [3:0] pstrb = 4'hF, dly = 4'h1, write_latency;
  logic pready, pslverr, mrs_req, auto_self_refresh, e;
  logic [15:0] mrs_value, applied;
  logic [7:0] refresh_banks;
  logic [2:0] c;
  smrts_dts_t dyn_term;
  smrts_srt_t temp_range;
  int fails = 0, comparisons = 0, cyc = 0;
  localparam logic [63:0] BANKS = 64'h80C0F0FC01030FFF;
  smrts_shadow smrts_shadow_inst (.*);
  smrts_mrs_partner smrts_mrs_partner_inst (.*);
  initial forever #20 clk = ~clk;
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk); psel <= 1; penable <= 0; pwrite <= wr; paddr <= a;
    pwdata <= d;
    @(posedge clk); penable <= 1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) fails++;
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic test_done;
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  always @(posedge clk) if (++cyc == 5000) begin fails++; test_done(); end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1;
    apb(0, 12'h000, 0); `CHK("reset", 32'h0, r)
    `CHK("wl reset", 4'h5, write_latency)
    apb(1, 12'h000, 32'hFFFF_FFFF); apb(0, 12'h000, 0);
    `CHK("upper", 32'h0000_FFFF, r)
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      w = {21'h0, c[1:0], 1'b0, c[0], c[1], c, c};
      apb(1, 12'h000, w); apb(0, 12'h000, 0); `CHK("word", w, r)
      `CHK("dts", c[1:0], dyn_term)
      `CHK("srt", c[0], temp_range)
      `CHK("asr", c[1], auto_self_refresh)
      `CHK("wl", 4'h5 + c, write_latency)
      `CHK("banks", BANKS[i*8+:8], refresh_banks)
      apb(0, 12'h004, 0); `CHK("dec", BANKS[i*8+:8], r[19:12])
    end
    pstrb <= 4'h1; apb(1, 12'h000, 32'h0); apb(0, 12'h000, 0);
    `CHK("lane", {16'h0, w[15:8], 8'h0}, r)
    for (int k = 0; k < 2; k++) begin
      dly <= k ? 4'h6 : 4'h0; apb(1, 12'h008, 1);
      for (int n = 0; n < 50; n++) begin
        @(posedge clk);
        if (mrs_req === 1'b0 && n > 0) break;
        if (n == 49) fails++;
      end
      `CHK("mrs", {w[15:8], 8'h0}, applied)
    end
    apb(0, 12'h00C, 0); `CHK("unmapped", 33'h1_0000_0000, {e, r})
    test_done();
  end
endmodule : smrts_shadow_bench
